// File: cfm_fault_manager.sv
// converter fault manager: protection classification, restart sequencing, x-cap discharge
// assumes comparator outputs from the analog front end and a cycle-start pulse from the pwm
`timescale 1ns/1ns
`default_nettype none
`include "cfm_map.svh"
module cfm_fault_manager #(
	parameter int BO_MASK_CYCLES = `CFM_BO_MASK_CYCLES,
	parameter int XCD_DET_CYCLES = `CFM_XCD_DET_CYCLES,
	parameter int DC_DET_CYCLES = `CFM_DC_DET_CYCLES,
	parameter int SUV_CYCLES = `CFM_SUV_CYCLES,
	parameter int PG_STABLE_CYCLES = `CFM_PG_STABLE_CYCLES,
	parameter int AR_CYCLES = `CFM_AR_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// primary comparators (asynchronous)
	input wire logic line_above_brownin,
	input wire logic line_below_brownout,
	input wire logic line_below_discharge_end,
	input wire logic line_ac_edge,
	input wire logic current_above_clamp,
	input wire logic ocp_above_level,
	input wire logic thermistor_below_level,
	input wire logic supply_below_off,
	input wire logic softstart_at_end,
	input wire logic softstart_overvoltage,
	// pwm timing (same clock)
	input wire logic cycle_start,
	input wire logic blanking_active,
	input wire logic low_side_gate_req,
	input wire logic high_side_gate_req,
	// secondary status (asynchronous)
	input wire logic secondary_contact,
	input wire logic sec_overcurrent,
	input wire logic sec_overvoltage,
	input wire logic sec_output_safe,
	input wire logic sec_undervoltage,
	input wire logic sec_supply_uvlo,
	input wire logic sec_overtemp,
	input wire logic sec_warning_temp,
	input wire logic load_switch_fitted,
	// configuration
	input wire logic [`CFM_SP_WIDTH-1:0] output_setpoint,
	input wire logic [`CFM_SP_WIDTH-1:0] pump_threshold,
	input wire logic flags_clear,
	// outputs
	output logic low_side_gate,
	output logic high_side_gate,
	output logic secondary_switch_en,
	output logic load_switch_on,
	output logic hard_reset_req,
	output logic warning_temp,
	output logic discharge_on,
	output logic charge_pump_en,
	output logic power_good_pin,
	output logic burst_mode,
	output logic lockout,
	output cfm_pkg::cfm_mode_t fault_mode,
	output cfm_pkg::cfm_flags_t fault_flags
);
	import cfm_pkg::*;

	localparam int NIN = 18;
	initial begin
		if (AR_CYCLES < 1 || BO_MASK_CYCLES < 1 || SUV_CYCLES < 1) $error("bad count");
		if (AR_CYCLES > 16) $error("restart count exceeds counter");
		if (XCD_DET_CYCLES < 1 || DC_DET_CYCLES < 1 || PG_STABLE_CYCLES < 1) $error("bad count");
	end

	// input synchronisation
	cfm_sync_if #(.W(NIN)) sif ();
	assign sif.raw = {line_above_brownin, line_below_brownout, line_below_discharge_end,
		line_ac_edge, current_above_clamp, ocp_above_level, thermistor_below_level,
		supply_below_off, softstart_at_end, softstart_overvoltage, secondary_contact,
		sec_overcurrent, sec_overvoltage, sec_output_safe, sec_undervoltage,
		sec_supply_uvlo, sec_overtemp, sec_warning_temp};
	cfm_sync #(.W(NIN)) u_sync (
		.clk(clk),
		.reset(reset),
		.port(sif.sync)
	);
	wire s_bi = sif.synced[17];
	wire s_bo = sif.synced[16];
	wire s_dend = sif.synced[15];
	wire s_acedge = sif.synced[14];
	wire s_clamp = sif.synced[13];
	wire s_ocp = sif.synced[12];
	wire s_otp = sif.synced[11];
	wire s_uv = sif.synced[10];
	wire s_ssend = sif.synced[9];
	wire s_ssov = sif.synced[8];
	wire s_contact = sif.synced[7];
	wire s_socp = sif.synced[6];
	wire s_sovp = sif.synced[5];
	wire s_safe = sif.synced[4];
	wire s_suv = sif.synced[3];
	wire s_suvlo = sif.synced[2];
	wire s_secondary_overtemp = sif.synced[1];
	wire s_wtp = sif.synced[0];

	// brown-in / brown-out
	logic line_ok_reg;
	logic [31:0] bo_cnt_reg;
	wire bo_expire = s_bo && (bo_cnt_reg == 32'(BO_MASK_CYCLES));
	always_ff @(posedge clk) begin
		if (reset) begin
			bo_cnt_reg <= '0;
			line_ok_reg <= 1'b0;
		end else begin
			bo_cnt_reg <= !s_bo ? '0 : (bo_expire ? bo_cnt_reg : bo_cnt_reg + 32'd1);
			if (s_bi)
				line_ok_reg <= 1'b1;
			else if (bo_expire)
				line_ok_reg <= 1'b0;
		end
	end
	wire brownout = !line_ok_reg;

	// x-cap discharge: plug removal is a missing ac edge, so dc also counts
	cfm_xcd_t xcd_reg;
	logic [31:0] ac_cnt_reg;
	logic [31:0] xd_cnt_reg;
	logic acedge_d_reg;
	wire ac_pulse = s_acedge && !acedge_d_reg;
	wire unplug = (ac_cnt_reg == 32'(DC_DET_CYCLES));
	always_ff @(posedge clk) begin
		if (reset) begin
			xcd_reg <= CFM_X_IDLE;
			ac_cnt_reg <= '0;
			xd_cnt_reg <= '0;
			acedge_d_reg <= 1'b0;
		end else begin
			acedge_d_reg <= s_acedge;
			ac_cnt_reg <= ac_pulse ? '0 : (unplug ? ac_cnt_reg : ac_cnt_reg + 32'd1);
			case (xcd_reg)
				CFM_X_IDLE: begin
					xd_cnt_reg <= '0;
					if (unplug && !s_dend)
						xcd_reg <= CFM_X_WAIT;
				end
				CFM_X_WAIT: begin
					xd_cnt_reg <= xd_cnt_reg + 32'd1;
					if (ac_pulse)
						xcd_reg <= CFM_X_IDLE;
					else if (xd_cnt_reg == 32'(XCD_DET_CYCLES - 1))
						xcd_reg <= CFM_X_DIS;
				end
				CFM_X_DIS: begin
					if (s_dend || ac_pulse)
						xcd_reg <= CFM_X_IDLE;
				end
				default: xcd_reg <= CFM_X_IDLE;
			endcase
		end
	end
	wire xcd_event = (xcd_reg != CFM_X_IDLE);
	assign discharge_on = (xcd_reg == CFM_X_DIS);

	// second-level overcurrent: warning then confirm on next cycle
	cfm_mode_t mode_reg;
	cfm_oc_t oc_reg;
	logic oc_seen_reg;
	wire oc_confirm = (oc_reg == CFM_OC_WARN) && s_ocp;
	always_ff @(posedge clk) begin
		if (reset) begin
			oc_reg <= CFM_OC_IDLE;
			oc_seen_reg <= 1'b0;
		end else begin
			case (oc_reg)
				CFM_OC_IDLE: begin
					oc_seen_reg <= 1'b0;
					if (s_ocp)
						oc_reg <= CFM_OC_WARN;
				end
				CFM_OC_WARN: begin
					if (cycle_start)
						oc_seen_reg <= 1'b1;
					if (oc_confirm && oc_seen_reg)
						oc_reg <= CFM_OC_TRIP;
					else if (cycle_start && oc_seen_reg)
						oc_reg <= CFM_OC_IDLE;
				end
				CFM_OC_TRIP: begin
					if (mode_reg != CFM_RUN)
						oc_reg <= CFM_OC_IDLE;
				end
				default: oc_reg <= CFM_OC_IDLE;
			endcase
		end
	end
	wire ocp_fault = (oc_reg == CFM_OC_TRIP);

	// secondary undervoltage persistence
	logic [31:0] suv_cnt_reg;
	wire suv_fault = s_suv && (suv_cnt_reg == 32'(SUV_CYCLES - 1));
	always_ff @(posedge clk) begin
		if (reset)
			suv_cnt_reg <= '0;
		else
			suv_cnt_reg <= !s_suv ? '0 : (suv_fault ? suv_cnt_reg : suv_cnt_reg + 32'd1);
	end

	// fault classification
	wire softstart_timeout_fault = s_ssend && !s_contact;
	wire cond_fault = brownout || xcd_event || s_otp;
	wire auto_fault = ocp_fault || s_uv || softstart_timeout_fault || suv_fault || s_suvlo;

	// restart sequencing
	logic [3:0] cyc_cnt_reg;
	logic uv_d_reg;
	wire supply_rise = uv_d_reg && !s_uv;
	always_ff @(posedge clk) begin
		if (reset) begin
			mode_reg <= CFM_RUN;
			cyc_cnt_reg <= '0;
			uv_d_reg <= 1'b0;
		end else begin
			uv_d_reg <= s_uv;
			case (mode_reg)
				CFM_RUN: begin
					cyc_cnt_reg <= '0;
					if (cond_fault)
						mode_reg <= CFM_COND;
					else if (auto_fault)
						mode_reg <= CFM_AUTO;
					else if (s_ssov && !s_contact)
						mode_reg <= CFM_BURST;
				end
				CFM_AUTO: begin
					if (brownout || xcd_event)
						mode_reg <= CFM_COND;
					else if (supply_rise && cyc_cnt_reg == 4'(AR_CYCLES - 1))
						mode_reg <= CFM_RUN;
					else if (supply_rise)
						cyc_cnt_reg <= cyc_cnt_reg + 4'd1;
				end
				CFM_COND: begin
					if (cond_fault)
						cyc_cnt_reg <= '0;
					else if (supply_rise)
						mode_reg <= CFM_RUN;
				end
				CFM_BURST: begin
					if (brownout || xcd_event)
						mode_reg <= CFM_COND;
					else if (s_contact)
						mode_reg <= CFM_RUN;
					else if (s_uv)
						mode_reg <= CFM_LOCK;
				end
				CFM_LOCK: begin
					if (brownout || xcd_event)
						mode_reg <= CFM_COND;
					else if (supply_rise)
						mode_reg <= CFM_RUN;
				end
				default: mode_reg <= CFM_RUN;
			endcase
		end
	end
	assign fault_mode = mode_reg;
	assign burst_mode = (mode_reg == CFM_BURST);
	assign lockout = (mode_reg == CFM_LOCK);

	// gate drive
	wire run = (mode_reg == CFM_RUN) && !cond_fault && !auto_fault;
	logic lsg_reg;
	logic hsg_reg;
	logic sec_sw_reg;
	always_ff @(posedge clk) begin
		if (reset) begin
			lsg_reg <= 1'b0;
			hsg_reg <= 1'b0;
			sec_sw_reg <= 1'b0;
		end else begin
			lsg_reg <= run && low_side_gate_req && !(s_clamp && !blanking_active);
			hsg_reg <= run && high_side_gate_req;
			if (s_sovp)
				sec_sw_reg <= 1'b0;
			else if (s_safe)
				sec_sw_reg <= run;
		end
	end
	assign low_side_gate = lsg_reg;
	assign high_side_gate = hsg_reg;
	assign secondary_switch_en = sec_sw_reg && run;

	// load switch, hard reset, warning
	logic ls_reg;
	logic hr_reg;
	logic secondary_overtemp_d_reg;
	logic wtp_reg;
	always_ff @(posedge clk) begin
		if (reset) begin
			ls_reg <= 1'b0;
			hr_reg <= 1'b0;
			secondary_overtemp_d_reg <= 1'b0;
			wtp_reg <= 1'b0;
		end else begin
			secondary_overtemp_d_reg <= s_secondary_overtemp;
			hr_reg <= s_secondary_overtemp && !secondary_overtemp_d_reg;
			wtp_reg <= s_wtp || s_secondary_overtemp;
			ls_reg <= run && !(s_socp && load_switch_fitted) && !s_secondary_overtemp;
		end
	end
	assign load_switch_on = ls_reg;
	assign hard_reset_req = hr_reg;
	assign warning_temp = wtp_reg;

	// power good and charge pump
	logic [31:0] pg_cnt_reg;
	logic pg_reg;
	logic cp_reg;
	wire stable = run && s_contact && !s_ssend;
	always_ff @(posedge clk) begin
		if (reset) begin
			pg_cnt_reg <= '0;
			pg_reg <= 1'b0;
			cp_reg <= 1'b0;
		end else begin
			pg_cnt_reg <= !stable ? '0 : (pg_reg ? pg_cnt_reg : pg_cnt_reg + 32'd1);
			pg_reg <= stable && (pg_reg || pg_cnt_reg == 32'(PG_STABLE_CYCLES - 1));
			cp_reg <= (output_setpoint < pump_threshold);
		end
	end
	assign power_good_pin = pg_reg;
	assign charge_pump_en = cp_reg;

	// sticky flags: set wins over clear; brownout wipes the rest
	cfm_flags_t flags_reg;
	cfm_flags_t flags_set;
	always_comb begin
		flags_set = '0;
		flags_set[`CFM_F_BO] = brownout;
		flags_set[`CFM_F_XCD] = xcd_event;
		flags_set[`CFM_F_OCP] = ocp_fault;
		flags_set[`CFM_F_OTP] = s_otp;
		flags_set[`CFM_F_UVLO] = s_uv;
		flags_set[`CFM_F_SOFTSTART_TIMEOUT] = softstart_timeout_fault;
		flags_set[`CFM_F_SSOV] = s_ssov && !s_contact;
		flags_set[`CFM_F_SOCP] = s_socp;
		flags_set[`CFM_F_SOVP] = s_sovp;
		flags_set[`CFM_F_SUVP] = suv_fault;
		flags_set[`CFM_F_SUVLO] = s_suvlo;
		flags_set[`CFM_F_SECONDARY_OVERTEMP] = s_secondary_overtemp;
		flags_set[`CFM_F_WTP] = s_wtp;
	end
	wire wipe = flags_set[`CFM_F_BO] || flags_set[`CFM_F_XCD];
	always_ff @(posedge clk) begin
		if (reset)
			flags_reg <= '0;
		else if (wipe)
			flags_reg <= flags_set;
		else
			flags_reg <= flags_set | (flags_clear ? '0 : flags_reg);
	end
	assign fault_flags = flags_reg;
endmodule : cfm_fault_manager
`default_nettype wire

// File: cfm_map.svh
// constants for the converter fault manager: timing counts, restart counts, flag positions
// assumes a 100 MHz clock; included by the package and the design files
//
// Notes on behaviour
// - no conversion until line sense has risen above brown-in level
// - line below brown-out longer than mask time stops conversion until brown-in
// - after blanking, low side gate cut when current exceeds peak clamp
// - first second-level overcurrent trip enters warning, converter keeps running
// - clean cycle in warning returns idle; second trip next cycle stops converter
// - confirmed second-level overcurrent is an auto-restart fault
// - thermistor below level stops conversion as conditioned-restart fault
// - primary supply below off level enters auto-restart fault
// - soft-start overvoltage stops switching, enters burst; no secondary contact ends in lockout
// - soft-start end without secondary contact is an auto-restart fault
// - brownout stops switching until the condition clears, conditioned restart
// - brownout clears every latched fault; a pending second-level overcurrent warning is kept
// - capacitor discharge event handled exactly like brownout
// - secondary overcurrent turns load switch off; without switch primary path protects
// - secondary overvoltage stops secondary switching until output is safe again
// - secondary undervoltage lasting 480us stops switching, awaits primary restart
// - secondary supply lockout stops switching, awaits primary restart
// - secondary overtemp keeps switching, opens load switch, issues hard reset; warning first
// - plug removal detected: wait detect delay, then discharge through line sense pin
// - discharge ends below end level or on reconnection; steady dc counts as removal
// - charge pump enabled only while output setpoint below configured threshold
// - power good holds second port off until soft-start done and stable
// - auto-restart waits six supply fall-and-rise cycles before restart
// - conditioned restart: condition gone, then one supply fall and rise
`ifndef CFM_MAP_SVH
`define CFM_MAP_SVH

`define CFM_CLK_MHZ 100
`define CFM_SUV_TIME_US 480
`define CFM_SUV_CYCLES (`CFM_SUV_TIME_US * `CFM_CLK_MHZ)
`define CFM_AR_CYCLES 6
`define CFM_BO_MASK_CYCLES 1000
`define CFM_XCD_DET_CYCLES 2000
`define CFM_DC_DET_CYCLES 3000
`define CFM_PG_STABLE_CYCLES 1000
`define CFM_SP_WIDTH 8
`define CFM_CP_THRESH_RST 8'h50

`define CFM_F_BO 0
`define CFM_F_XCD 1
`define CFM_F_OCP 2
`define CFM_F_OTP 3
`define CFM_F_UVLO 4
`define CFM_F_SOFTSTART_TIMEOUT 5
`define CFM_F_SSOV 6
`define CFM_F_SOCP 7
`define CFM_F_SOVP 8
`define CFM_F_SUVP 9
`define CFM_F_SUVLO 10
`define CFM_F_SECONDARY_OVERTEMP 11
`define CFM_F_WTP 12
`define CFM_NFLAGS 13

`endif

// File: cfm_pkg.sv
// types for the converter fault manager
// assumes cfm_map.svh in the same folder
`include "cfm_map.svh"
package cfm_pkg;
	typedef enum logic [1:0] {CFM_OC_IDLE, CFM_OC_WARN, CFM_OC_TRIP} cfm_oc_t;
	typedef enum logic [2:0] {CFM_RUN, CFM_AUTO, CFM_COND, CFM_BURST, CFM_LOCK} cfm_mode_t;
	typedef enum logic [1:0] {CFM_X_IDLE, CFM_X_WAIT, CFM_X_DIS} cfm_xcd_t;
	typedef logic [`CFM_NFLAGS-1:0] cfm_flags_t;
endpackage : cfm_pkg

// File: cfm_sync_if.sv
// carrier between the fault manager and its input synchroniser
// assumes one clock shared by both ends
`timescale 1ns/1ns
`default_nettype none
interface cfm_sync_if #(parameter int W = 1);
	logic [W-1:0] raw;
	logic [W-1:0] synced;
	modport src (output raw, input synced);
	modport sync (input raw, output synced);
endinterface : cfm_sync_if
`default_nettype wire

// File: cfm_sync.sv
// two flip-flop synchroniser for comparator and status inputs
// assumes inputs asynchronous to clk
`timescale 1ns/1ns
`default_nettype none
module cfm_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic reset,
	cfm_sync_if.sync port
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] out_reg;
	initial begin
		if (W < 1) $error("cfm_sync width must be positive");
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_reg <= '0;
			out_reg <= '0;
		end else begin
			meta_reg <= port.raw;
			out_reg <= meta_reg;
		end
	end
	assign port.synced = out_reg;
endmodule : cfm_sync
`default_nettype wire

// File: cfm_fault_manager_assertions.sv
// checker for the fault manager ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
`include "cfm_map.svh"
module cfm_fault_manager_assertions (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// inputs
	input wire logic current_above_clamp,
	input wire logic blanking_active,
	input wire logic line_below_discharge_end,
	input wire logic flags_clear,
	input wire logic [`CFM_SP_WIDTH-1:0] output_setpoint,
	input wire logic [`CFM_SP_WIDTH-1:0] pump_threshold,
	// outputs
	input wire logic low_side_gate,
	input wire logic high_side_gate,
	input wire logic hard_reset_req,
	input wire logic discharge_on,
	input wire logic charge_pump_en,
	input wire logic power_good_pin,
	input wire logic burst_mode,
	input wire logic lockout,
	input wire cfm_pkg::cfm_mode_t fault_mode,
	input wire cfm_pkg::cfm_flags_t fault_flags
);
	import cfm_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence stopped_s;
		(fault_mode != CFM_RUN) [*2];
	endsequence
	sequence clamp_s;
		(current_above_clamp && !blanking_active) [*4];
	endsequence
	gates_off_a: assert property (stopped_s |-> !low_side_gate && !high_side_gate)
		else $error("gate driven while stopped");
	clamp_cut_a: assert property (clamp_s |-> !low_side_gate)
		else $error("low gate on above clamp");
	hr_pulse_a: assert property (hard_reset_req |=> !hard_reset_req)
		else $error("hard reset longer than one cycle");
	pump_gate_a: assert property (charge_pump_en && $stable(output_setpoint)
		&& $stable(pump_threshold) |-> output_setpoint < pump_threshold)
		else $error("pump on above threshold");
	dis_end_a: assert property (line_below_discharge_end [*4] |-> !discharge_on)
		else $error("discharge below end level");
	bo_wipe_a: assert property ($rose(fault_flags[`CFM_F_BO])
		|-> (fault_flags & $past(fault_flags) & 13'h1ffc) == 13'h0)
		else $error("flags kept over brownout");
	flag_sticky_a: assert property ($fell(fault_flags[`CFM_F_OCP]) |-> $past(flags_clear)
		|| fault_flags[`CFM_F_BO] || fault_flags[`CFM_F_XCD])
		else $error("flag lost");
	ocp_auto_a: assert property ($rose(fault_flags[`CFM_F_OCP])
		|-> ##[0:2] fault_mode == CFM_AUTO)
		else $error("ocp not auto-restart");
	otp_cond_a: assert property ($rose(fault_flags[`CFM_F_OTP])
		|-> ##[0:2] fault_mode == CFM_COND)
		else $error("otp not conditioned");
	mode_view_a: assert property (burst_mode == (fault_mode == CFM_BURST)
		&& lockout == (fault_mode == CFM_LOCK))
		else $error("burst or lockout mismatch");
	pg_run_a: assert property ($rose(power_good_pin) |-> $past(fault_mode) == CFM_RUN)
		else $error("power good while stopped");
endmodule : cfm_fault_manager_assertions
`default_nettype wire

// File: cfm_line_model.sv
// line input model: comparators, ac edges, x-cap charge
// assumes the bench plugs and dips the line
`timescale 1ns/1ns
`default_nettype none
module cfm_line_model (
	// clock
	input wire logic clk,
	// line control
	input wire logic plugged,
	input wire logic line_low,
	input wire logic discharge_on,
	// comparators
	output logic line_above_brownin,
	output logic line_below_brownout,
	output logic line_below_discharge_end,
	output logic line_ac_edge
);
	logic [1:0] ac_reg = 2'h0;
	logic [3:0] dis_reg = 4'h0;
	assign line_above_brownin = plugged && !line_low;
	assign line_below_brownout = !line_above_brownin;
	// unplugged line shows no ac edges, as dc would
	assign line_ac_edge = ac_reg[1];
	// x-cap drains only while discharging
	assign line_below_discharge_end = dis_reg == 4'ha;
	always_ff @(posedge clk) begin
		if (plugged) ac_reg <= ac_reg + 2'h1;
		if (plugged) dis_reg <= 4'h0;
		else if (discharge_on && dis_reg != 4'ha) dis_reg <= dis_reg + 4'h1;
	end
endmodule : cfm_line_model
`default_nettype wire

// File: test_cfm_fault_manager.sv
// bench for the fault manager with a line model
// assumes short counts set by parameters
`timescale 1ns/1ns
`default_nettype none
`include "cfm_map.svh"
module test_cfm_fault_manager;
	import cfm_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic plugged, line_low, line_above_brownin, line_below_brownout;
	logic line_below_discharge_end, line_ac_edge, current_above_clamp, ocp_above_level;
	logic thermistor_below_level, supply_below_off, softstart_at_end, softstart_overvoltage;
	logic cycle_start, blanking_active, low_side_gate_req, high_side_gate_req;
	logic secondary_contact, sec_overcurrent, sec_overvoltage, sec_output_safe;
	logic sec_undervoltage, sec_supply_uvlo, sec_overtemp, sec_warning_temp;
	logic load_switch_fitted, flags_clear, low_side_gate, high_side_gate, secondary_switch_en;
	logic load_switch_on, hard_reset_req, warning_temp, discharge_on, charge_pump_en;
	logic power_good_pin, burst_mode, lockout;
	logic [7:0] output_setpoint, pump_threshold;
	cfm_mode_t fault_mode;
	cfm_flags_t fault_flags;
	int n_errors = 0;
	int n_tests = 0;
	cfm_line_model line_u (.clk, .plugged, .line_low, .discharge_on, .line_above_brownin,
		.line_below_brownout, .line_below_discharge_end, .line_ac_edge);
	cfm_fault_manager #(.BO_MASK_CYCLES(20), .XCD_DET_CYCLES(20), .DC_DET_CYCLES(40),
		.SUV_CYCLES(30), .PG_STABLE_CYCLES(20), .AR_CYCLES(6)) dut_u (.clk, .reset,
		.line_above_brownin, .line_below_brownout, .line_below_discharge_end, .line_ac_edge,
		.current_above_clamp, .ocp_above_level, .thermistor_below_level, .supply_below_off,
		.softstart_at_end, .softstart_overvoltage, .cycle_start, .blanking_active,
		.low_side_gate_req, .high_side_gate_req, .secondary_contact, .sec_overcurrent,
		.sec_overvoltage, .sec_output_safe, .sec_undervoltage, .sec_supply_uvlo,
		.sec_overtemp, .sec_warning_temp, .load_switch_fitted, .output_setpoint,
		.pump_threshold, .flags_clear, .low_side_gate, .high_side_gate, .secondary_switch_en,
		.load_switch_on, .hard_reset_req, .warning_temp, .discharge_on, .charge_pump_en,
		.power_good_pin, .burst_mode, .lockout, .fault_mode, .fault_flags);
	initial forever #5 clk = ~clk;
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
			n_errors++;
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task final_report;
		$display("errors %0d, checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report
	task automatic wait_mode(input cfm_mode_t m);
		for (int i = 0; i < 300 && fault_mode !== m; i++) @(negedge clk);
		chk("fault_mode wait", m, fault_mode);
		if (fault_mode !== m) final_report();
	endtask : wait_mode
	task sup(input int n);
		repeat (n) begin
			supply_below_off = 1'b1;
			cyc(4);
			supply_below_off = 1'b0;
			cyc(4);
		end
	endtask : sup
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
		cyc(4);
	endtask : pulse
	task t_startup;
		low_side_gate_req = 1'b1;
		high_side_gate_req = 1'b1;
		cyc(10);
		chk("low_side_gate", 16'h0, low_side_gate);
		chk("bo flag", 16'h1, fault_flags[`CFM_F_BO]);
		plugged = 1'b1;
		sup(1);
		cyc(2);
		chk("gates", 16'h3, {low_side_gate, high_side_gate});
		chk("power_good_pin", 16'h0, power_good_pin);
		pulse(flags_clear);
		chk("fault_flags", 16'h0, fault_flags);
	endtask : t_startup
	task t_clamp;
		blanking_active = 1'b1;
		current_above_clamp = 1'b1;
		cyc(5);
		chk("low_side_gate", 16'h1, low_side_gate);
		blanking_active = 1'b0;
		cyc(5);
		chk("low_side_gate", 16'h0, low_side_gate);
		chk("fault_mode", CFM_RUN, fault_mode);
		current_above_clamp = 1'b0;
		cyc(4);
	endtask : t_clamp
	task t_ocp;
		pulse(ocp_above_level);
		chk("fault_mode", CFM_RUN, fault_mode);
		pulse(cycle_start);
		pulse(cycle_start);
		pulse(ocp_above_level);
		chk("fault_mode", CFM_RUN, fault_mode);
		pulse(cycle_start);
		pulse(ocp_above_level);
		wait_mode(CFM_AUTO);
		chk("ocp flag", 16'h1, fault_flags[`CFM_F_OCP]);
		chk("gates", 16'h0, {low_side_gate, high_side_gate});
		sup(5);
		chk("fault_mode", CFM_AUTO, fault_mode);
		sup(1);
		chk("fault_mode", CFM_RUN, fault_mode);
	endtask : t_ocp
	task t_otp;
		thermistor_below_level = 1'b1;
		wait_mode(CFM_COND);
		chk("otp flag", 16'h1, fault_flags[`CFM_F_OTP]);
		sup(1);
		chk("fault_mode", CFM_COND, fault_mode);
		thermistor_below_level = 1'b0;
		cyc(4);
		chk("fault_mode", CFM_COND, fault_mode);
		sup(1);
		chk("fault_mode", CFM_RUN, fault_mode);
	endtask : t_otp
	task automatic t_secondary_overtemp;
		int n = 0;
		sec_overtemp = 1'b1;
		repeat (10) begin
			cyc(1);
			if (hard_reset_req === 1'b1) n++;
		end
		chk("hard resets", 16'h1, n);
		chk("load_switch_on", 16'h0, load_switch_on);
		chk("low_side_gate", 16'h1, low_side_gate);
		sec_overtemp = 1'b0;
	endtask : t_secondary_overtemp
	task t_pump;
		output_setpoint = 8'h60;
		cyc(4);
		chk("charge_pump_en", 16'h0, charge_pump_en);
		output_setpoint = 8'h30;
		cyc(4);
		chk("charge_pump_en", 16'h1, charge_pump_en);
	endtask : t_pump
	task t_sec;
		{sec_warning_temp, sec_overvoltage, sec_overcurrent} = '1;
		cyc(4);
		chk("warning_temp", 16'h1, warning_temp);
		chk("secondary_switch_en", 16'h0, secondary_switch_en);
		chk("load_switch_on", 16'h0, load_switch_on);
		{sec_warning_temp, sec_overvoltage, sec_overcurrent} = '0;
		cyc(4);
		chk("sec switches", 16'h3, {secondary_switch_en, load_switch_on});
		chk("power_good_pin", 16'h1, power_good_pin);
		sec_supply_uvlo = 1'b1;
		wait_mode(CFM_AUTO);
		sec_supply_uvlo = 1'b0;
		sup(6);
		chk("fault_mode", CFM_RUN, fault_mode);
		sec_undervoltage = 1'b1;
		cyc(20);
		chk("fault_mode", CFM_RUN, fault_mode);
		wait_mode(CFM_AUTO);
		sec_undervoltage = 1'b0;
		sup(6);
		chk("fault_mode", CFM_RUN, fault_mode);
		{secondary_contact, softstart_at_end} = 2'b01;
		wait_mode(CFM_AUTO);
		softstart_at_end = 1'b0;
		sup(6);
		softstart_overvoltage = 1'b1;
		wait_mode(CFM_BURST);
		chk("burst_mode", 16'h1, burst_mode);
		{softstart_overvoltage, supply_below_off} = 2'b01;
		wait_mode(CFM_LOCK);
		chk("lockout", 16'h1, lockout);
		{secondary_contact, supply_below_off} = 2'b10;
		wait_mode(CFM_RUN);
		chk("sec flags", 16'hf, {fault_flags[`CFM_F_SOFTSTART_TIMEOUT], fault_flags[`CFM_F_SSOV],
			fault_flags[`CFM_F_SUVP], fault_flags[`CFM_F_SUVLO]});
	endtask : t_sec
	task t_brownout;
		line_low = 1'b1;
		cyc(8);
		line_low = 1'b0;
		cyc(4);
		chk("fault_mode", CFM_RUN, fault_mode);
		line_low = 1'b1;
		wait_mode(CFM_COND);
		chk("fault_flags", 16'h1, fault_flags);
		chk("gates", 16'h0, {low_side_gate, high_side_gate});
		line_low = 1'b0;
		sup(1);
		wait_mode(CFM_RUN);
	endtask : t_brownout
	task automatic t_xcd;
		plugged = 1'b0;
		cyc(30);
		chk("discharge_on", 16'h0, discharge_on);
		for (int i = 0; i < 200 && discharge_on !== 1'b1; i++) cyc(1);
		chk("discharge_on", 16'h1, discharge_on);
		if (discharge_on !== 1'b1) final_report();
		chk("xcd flag", 16'h1, fault_flags[`CFM_F_XCD]);
		chk("fault_mode", CFM_COND, fault_mode);
		cyc(20);
		chk("discharge_on", 16'h0, discharge_on);
		plugged = 1'b1;
		cyc(4);
		sup(1);
		wait_mode(CFM_RUN);
	endtask : t_xcd
	initial begin
		{plugged, line_low, current_above_clamp, ocp_above_level, thermistor_below_level} = '0;
		{supply_below_off, softstart_at_end, softstart_overvoltage, cycle_start} = '0;
		{blanking_active, low_side_gate_req, high_side_gate_req, sec_overcurrent} = '0;
		{sec_overvoltage, sec_undervoltage, sec_supply_uvlo, sec_overtemp} = '0;
		{sec_warning_temp, flags_clear} = '0;
		{secondary_contact, sec_output_safe, load_switch_fitted} = '1;
		output_setpoint = 8'h30;
		pump_threshold = 8'h50;
		repeat (3) @(posedge clk);
		@(negedge clk) reset = 1'b0;
		t_startup();
		t_clamp();
		t_ocp();
		t_otp();
		t_secondary_overtemp();
		t_pump();
		t_sec();
		t_brownout();
		t_xcd();
		final_report();
	end
endmodule : test_cfm_fault_manager
bind cfm_fault_manager cfm_fault_manager_assertions chk_u (.clk, .reset, .current_above_clamp,
	.blanking_active, .line_below_discharge_end, .flags_clear, .output_setpoint,
	.pump_threshold, .low_side_gate, .high_side_gate, .hard_reset_req, .discharge_on,
	.charge_pump_en, .power_good_pin, .burst_mode, .lockout, .fault_mode, .fault_flags);
`default_nettype wire
